// ### hw/mxscp_pkg.sv
package mxscp_pkg;
  localparam int          CHANNELS   = 8;
  localparam int          CH_BITS    = 3;
  localparam int          ATT_BITS   = 6;
  localparam int          BYTE_BITS  = 8;
  localparam int          ADDR_FLAG  = 7;
  localparam int          LEFT_BIT   = 4;
  localparam int          RIGHT_BIT  = 3;
  localparam logic [5:0]  ATT_RESET  = 6'h00;
  localparam logic [7:0]  SHIFT_RESET = 8'h00;
endpackage

// ### hw/mxscp_sync.sv
module mxscp_sync
(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed
  {
    logic s1_r;
    logic s2_r;
  } mxscp_sync_st_t;
  mxscp_sync_st_t st_r;
  mxscp_sync_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1_r = din;
    st_nxt.s2_r = st_r.s1_r;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign dout = st_r.s2_r;
endmodule

// ### hw/mxscp_shift.sv
module mxscp_shift
(
  input  wire logic       sclk,
  input  wire logic       shift_en_n,
  input  wire logic       sdi,
  output logic [7:0]      shift_q,
  output logic            sdo
);
  typedef struct packed
  {
    logic [7:0] sr_r;
  } mxscp_shift_st_t;
  mxscp_shift_st_t st_r = '0;
  mxscp_shift_st_t st_nxt;

  // shift only inside the window
  always_comb
  begin
    st_nxt = st_r;
    if (!shift_en_n)
      st_nxt.sr_r = {st_r.sr_r[6:0], sdi};
  end

  always_ff @(posedge sclk)
  begin
    st_r <= st_nxt;
  end

  assign shift_q = st_r.sr_r;
  assign sdo     = st_r.sr_r[7];
endmodule

// ### hw/mxscp_top.sv
// Operation
// [R1] supports 3-wire mode and 4-wire mode with separate latch strobe
// [R2] in 4-wire mode bits shift only while shift window is low
// [R3] shifted byte reaches control registers only at latch rising edge
// [R4] host sends each byte most significant bit first
// [R5] 3-wire: frame low for transfer, rising edge after 8 bits latches
// [R6] address byte: bit7 set, bit4 left, bit3 right, bits2-0 channel
// [R7] latched address sets channel left and right switches
// [R8] data byte: bit7 clear, bits5-0 attenuation, zero is none
// [R9] attenuation value is decibels of cut, larger is quieter
// [R10] any latched byte with top bit one decodes as address
// [R11] host masks attenuation values with 3F before sending
// [R12] host always shifts all eight bits of a byte; the bench also sends one 6-bit frame
// [R13] shift register keeps older bits across short transfers
// [R14] chain load: lines low, two bytes, lines high
// [R15] serial out feeds next device, all latch at same edge
// [R16] serial output shows shift register top bit continuously
// [R17] data bytes keep updating the last addressed channel
// [R18] silence input mutes all channels without touching levels
// [R19] address byte with routing bit re-enables muted channel
// [R20] data sampled on serial clock rising edge in window
// [R21] after reset all channels muted with routing off
module mxscp_top
#(
  parameter int CHANNELS = mxscp_pkg::CHANNELS
)
(
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  sclk,
  input  wire logic                  sdi,
  input  wire logic                  shift_win_n,
  input  wire logic                  latch_stb,
  input  wire logic                  four_wire,
  input  wire logic                  silence,
  output logic                       sdo,
  output logic [CHANNELS-1:0]        route_left,
  output logic [CHANNELS-1:0]        route_right,
  output logic [CHANNELS-1:0]        ch_muted,
  output logic [CHANNELS*6-1:0]      atten,
  output logic [2:0]                 cur_ch
);
  //////////////////////////////////////////////////////////////////////
  // link side shift register
  logic       win_n;
  logic [7:0] shift_q;
  logic       sdo_link;

  // [R1] frame mode select
  // [R2] shift window per mode
  assign win_n = four_wire ? shift_win_n : latch_stb;

  // [R20] rising sclk sampling
  // [R13] bits kept across frames
  // [R16] top bit drives output
  // [R15] serial chain output
  mxscp_shift u_shift
  (
    .sclk       (sclk),
    .shift_en_n (win_n),
    .sdi        (sdi),
    .shift_q    (shift_q),
    .sdo        (sdo_link)
  );

  //////////////////////////////////////////////////////////////////////
  // crossings
  logic            stb_s;
  logic            sil_s;
  logic            sdo_s;
  logic [7:0]      byte_s;

  mxscp_sync u_sync_stb
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .din      (latch_stb),
    .dout     (stb_s)
  );

  mxscp_sync u_sync_sil
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .din      (silence),
    .dout     (sil_s)
  );

  mxscp_sync u_sync_sdo
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .din      (sdo_link),
    .dout     (sdo_s)
  );

  // shift word stable while strobe high; sampled after strobe sync
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_bsync
      mxscp_sync u_bs
      (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .din      (shift_q[gi]),
        .dout     (byte_s[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // core state
  typedef struct packed
  {
    logic                  stb_d_r;
    logic                  hold_r;
    logic [1:0]            wait_r;
    logic [2:0]            ch_r;
    logic [CHANNELS-1:0]   left_r;
    logic [CHANNELS-1:0]   right_r;
    logic [CHANNELS-1:0]   muted_r;
    logic [CHANNELS*6-1:0] att_r;
    logic                  sdo_r;
  } mxscp_st_t;

  mxscp_st_t st_r;
  mxscp_st_t st_nxt;
  logic      rise;
  logic [2:0] a_ch;

  assign rise = stb_s & ~st_r.stb_d_r;
  assign a_ch = byte_s[2:0];

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.stb_d_r = stb_s;
    st_nxt.sdo_r   = sdo_s;
    // [R3] latch on strobe rise
    // [R5] frame rise latches byte
    // [R15] tandem latch on rise
    // wait two cycles so synced byte reflects final shift
    if (rise)
    begin
      st_nxt.hold_r = 1'b1;
      st_nxt.wait_r = 2'h0;
    end
    else if (st_r.hold_r && st_r.wait_r != 2'h2)
    begin
      st_nxt.wait_r = st_r.wait_r + 2'h1;
    end
    else if (st_r.hold_r)
    begin
      st_nxt.hold_r = 1'b0;
      // [R10] top bit means address
      // [R6] address field decode
      if (byte_s[mxscp_pkg::ADDR_FLAG])
      begin
        st_nxt.ch_r = a_ch;
        // [R7] routing switches set
        st_nxt.left_r[a_ch]  = byte_s[mxscp_pkg::LEFT_BIT];
        st_nxt.right_r[a_ch] = byte_s[mxscp_pkg::RIGHT_BIT];
        // [R19] routing re-enables channel
        st_nxt.muted_r[a_ch] = ~(byte_s[mxscp_pkg::LEFT_BIT]
                               | byte_s[mxscp_pkg::RIGHT_BIT]);
      end
      else
      begin
        // [R8] attenuation field store
        // [R9] value is cut in dB
        // [R17] last addressed channel
        st_nxt.att_r[st_r.ch_r*6 +: 6] =
          byte_s[mxscp_pkg::ATT_BITS-1:0];
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      // [R21] muted and unrouted at reset
      st_r         <= '0;
      st_r.muted_r <= '1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs
  logic [CHANNELS-1:0] mute_out_r;

  // [R18] global silence keeps levels
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      mute_out_r <= '1;
    else
      mute_out_r <= st_nxt.muted_r | {CHANNELS{sil_s}};
  end

  assign sdo         = st_r.sdo_r;
  assign route_left  = st_r.left_r;
  assign route_right = st_r.right_r;
  assign atten       = st_r.att_r;
  assign cur_ch      = st_r.ch_r;
  assign ch_muted    = mute_out_r;

  //////////////////////////////////////////////////////////////////////
  // checks
  sequence s_rise;
    rise;
  endsequence

  sequence s_addr_commit;
    st_r.hold_r && st_r.wait_r == 2'h2 && byte_s[mxscp_pkg::ADDR_FLAG];
  endsequence

  sequence s_data_commit;
    st_r.hold_r && st_r.wait_r == 2'h2 && !byte_s[mxscp_pkg::ADDR_FLAG];
  endsequence

  // [R18] silence mutes all
  a_silence_mutes: assert property (@(posedge core_clk) // [R18]
    disable iff (sys_rst) sil_s |=> ch_muted == '1)
    else $error("silence did not mute");

  // [R7] left switch set
  a_addr_route: assert property (@(posedge core_clk) // [R7]
    disable iff (sys_rst)
    s_addr_commit |=> route_left[$past(a_ch)] == $past(byte_s[4]))
    else $error("left route wrong");

  // [R7] right switch set
  a_addr_right: assert property (@(posedge core_clk) // [R7]
    disable iff (sys_rst)
    s_addr_commit |=> route_right[$past(a_ch)] == $past(byte_s[3]))
    else $error("right route wrong");

  // [R17] data keeps channel
  a_data_keeps: assert property (@(posedge core_clk) // [R17]
    disable iff (sys_rst)
    s_data_commit |=> cur_ch == $past(cur_ch))
    else $error("data changed channel");

  // [R3] no update without strobe
  a_no_rise_hold: assert property (@(posedge core_clk) // [R3]
    disable iff (sys_rst)
    (!st_r.hold_r && !rise) |=> $stable(atten))
    else $error("update without strobe");

  // [R3] strobe rise arms latch
  a_rise_arms: assert property (@(posedge core_clk) // [R3]
    disable iff (sys_rst) s_rise |=> st_r.hold_r)
    else $error("latch not armed");

  // [R5] latch finishes in time
  a_rise_commit: assert property (@(posedge core_clk) // [R5]
    disable iff (sys_rst) s_rise |-> ##4 (!st_r.hold_r || rise))
    else $error("latch not finished");

  // [R5] wait count bounded
  a_wait_bound: assert property (@(posedge core_clk) // [R5]
    disable iff (sys_rst) st_r.hold_r |-> st_r.wait_r <= 2'h2)
    else $error("wait count out of range");

  // [R19] routing bit unmutes
  a_reenable: assert property (@(posedge core_clk) // [R19]
    disable iff (sys_rst)
    (st_r.hold_r && st_r.wait_r == 2'h2 && byte_s[7]
     && (byte_s[4] || byte_s[3]) && !sil_s)
    |=> !ch_muted[$past(a_ch)])
    else $error("channel not re-enabled");

  // [R7] no routing bit mutes
  a_route_off: assert property (@(posedge core_clk) // [R7]
    disable iff (sys_rst)
    (st_r.hold_r && st_r.wait_r == 2'h2 && byte_s[7]
     && !byte_s[4] && !byte_s[3])
    |=> ch_muted[$past(a_ch)])
    else $error("unrouted channel not muted");

  // [R19] address keeps levels
  a_addr_levels: assert property (@(posedge core_clk) // [R19]
    disable iff (sys_rst) s_addr_commit |=> $stable(atten))
    else $error("address changed level");

  // [R8] attenuation stored
  a_att_field: assert property (@(posedge core_clk) // [R8]
    disable iff (sys_rst)
    s_data_commit |=> atten[$past(cur_ch)*6 +: 6] == $past(byte_s[5:0]))
    else $error("attenuation not stored");

  // [R8] data leaves routing
  a_data_route: assert property (@(posedge core_clk) // [R8]
    disable iff (sys_rst)
    s_data_commit |=> $stable(route_left) && $stable(route_right))
    else $error("data changed routing");

  // [R10] top bit decodes address
  a_addr_decode: assert property (@(posedge core_clk) // [R10]
    disable iff (sys_rst)
    s_addr_commit |=> cur_ch == $past(byte_s[2:0]))
    else $error("address not decoded");

  // [R18] silence keeps levels
  a_silence_keeps: assert property (@(posedge core_clk) // [R18]
    disable iff (sys_rst)
    (sil_s && !st_r.hold_r && !rise) |=> $stable(atten))
    else $error("silence changed level");

  // [R21] reset mutes, clears left routing and levels
  a_reset_muted: assert property (@(posedge core_clk) // [R21]
    sys_rst |=> ch_muted == '1 && route_left == '0 && atten == '0)
    else $error("reset state wrong");

  // [R15] chain output follows
  a_sdo_chain: assert property (@(posedge core_clk) // [R15]
    disable iff (sys_rst) !sys_rst |=> sdo == $past(sdo_s))
    else $error("serial output lags wrong");

  // [R2] no shift outside window
  a_window_hold: assert property (@(posedge sclk) // [R2]
    win_n |=> shift_q == $past(shift_q))
    else $error("shift outside window");

  // [R20] sample on rising sclk
  a_shift_in: assert property (@(posedge sclk) // [R20]
    !win_n |=> shift_q[0] == $past(sdi))
    else $error("serial bit not taken");

  // [R13] older bits move up
  a_shift_keep: assert property (@(posedge sclk) // [R13]
    !win_n |=> shift_q[7:1] == $past(shift_q[6:0]))
    else $error("older bits lost");
endmodule

// ### tb/mxscp_host.sv
module mxscp_host
(
  output logic sclk,
  output logic sdi,
  output logic shift_win_n,
  output logic latch_stb
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sclk = 1'b0;
    sdi = 1'b0;
    shift_win_n = 1'b1;
    latch_stb = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // msb first frame
  task automatic xfer(input logic [15:0] d, input int n, input bit fw);
    latch_stb <= 1'b0;
    shift_win_n <= ~fw;
    #15;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi <= d[i];
      #7.5 sclk <= 1'b1;
      #7.5 sclk <= 1'b0;
    end
    sdi <= ~sdi;
    #15 shift_win_n <= 1'b1;
    if (fw)
      repeat (2)
      begin
        #7.5 sclk <= 1'b1;
        #7.5 sclk <= 1'b0;
        sdi <= ~sdi;
      end
    #15 latch_stb <= 1'b1;
  endtask
endmodule

// ### tb/mxscp_top_bench.sv
module mxscp_top_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk;
  logic        sys_rst;
  logic        four_wire;
  logic        silence;
  logic        sclk;
  logic        sdi;
  logic        shift_win_n;
  logic        latch_stb;
  logic        sdo;
  logic [7:0]  route_left;
  logic [7:0]  route_right;
  logic [7:0]  ch_muted;
  logic [47:0] atten;
  logic [2:0]  cur_ch;
  logic [7:0]  rl;
  logic [7:0]  rr;
  logic [7:0]  mu;
  logic [47:0] at;
  logic [2:0]  cur;
  logic [7:0]  rnd;
  int          sr;
  int          n_mismatch;
  int          num_checks;

  mxscp_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .sclk(sclk),
    .sdi(sdi), .shift_win_n(shift_win_n), .latch_stb(latch_stb),
    .four_wire(four_wire), .silence(silence), .sdo(sdo),
    .route_left(route_left), .route_right(route_right),
    .ch_muted(ch_muted), .atten(atten), .cur_ch(cur_ch));
  mxscp_host host (.sclk(sclk), .sdi(sdi), .shift_win_n(shift_win_n),
    .latch_stb(latch_stb));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string nm, input logic [47:0] e,
                     input logic [47:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_all;
    chk("left", 48'(rl), 48'(route_left));
    chk("right", 48'(rr), 48'(route_right));
    chk("muted", 48'(mu | {8{silence}}), 48'(ch_muted));
    chk("atten", at, atten);
    chk("chan", 48'(cur), 48'(cur_ch));
    chk("sdo", 48'(sr[7]), 48'(sdo));
  endtask
  task automatic send(input logic [15:0] d, input int n, input bit fw);
    logic [7:0] b;
    @(posedge core_clk) four_wire <= fw;
    repeat (2) @(posedge core_clk);
    host.xfer(d, n, fw);
    sr = ((sr << n) | int'(d)) & 32'h0000_00FF;
    b = sr[7:0];
    if (b[7])
    begin
      cur = b[2:0];
      rl[cur] = b[4];
      rr[cur] = b[3];
      mu[cur] = ~(b[4] | b[3]);
    end
    else
      at[cur*6 +: 6] = b[5:0];
    repeat (12) @(negedge core_clk);
    cmp_all();
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    n_mismatch++;
    finish_test();
  end
  initial
  begin
    sys_rst = 1'b1;
    four_wire = 1'b0;
    silence = 1'b0;
    rl = 8'h00;
    rr = 8'h00;
    mu = 8'hFF;
    at = 48'h0;
    cur = 3'h0;
    sr = 0;
    rnd = 8'h5A;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(negedge core_clk);
    cmp_all();
    $display("test reset done");
    for (int c = 0; c < 8; c++)
    begin
      rnd = lfsr(rnd);
      send(16'(8'h80 | (rnd & 8'h18) | 8'(c)), 8, c[0]);
      rnd = lfsr(rnd);
      send(16'(rnd & 8'h3F), 8, ~c[0]);
    end
    $display("test channels done");
    send(16'h0026, 8, 1'b1);
    send(16'h0011, 6, 1'b0);
    $display("test short done");
    send(16'h3F9A, 16, 1'b1);
    $display("test chain done");
    @(posedge core_clk) silence <= 1'b1;
    repeat (8) @(negedge core_clk);
    cmp_all();
    @(posedge core_clk) silence <= 1'b0;
    send(16'h009B, 8, 1'b0);
    $display("test silence done");
    finish_test();
  end
endmodule
